// ### hdl/gpio_group_config_bank.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - A direction bit of 0 makes its pin an output and 1 an input, and all pins start as inputs.
// - Data bits of output pins are read and written by software and the written value drives the pin.
// - Data bits of input pins read back the pin level and ignore writes.
// - An inversion bit of 1 flips the relation between data bit and pin in both directions.
// - Any rising or falling edge on a pin of an active group sets its bit in the group's event status register.
// - Reading an event status register clears it, writes do nothing, and it starts at zero.
// - Activation bit 2 enables group six and bit 1 group five, with group five on and group six off after reset.
// - Activation bit 0 turns the watchdog timeout output and the power LED output on or off.
// - Two registers hold a 4-byte aligned base address, valid between 100h and FF8h, zero after reset.
// - Group six data starts at 1Fh and every other data and inversion register at zero.
module gpio_group_config_bank (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // Group four pins.
  input  wire logic [7:0] group_four_pins_in,
  output var  logic [7:0] group_four_pins_out,
  output var  logic [7:0] group_four_pins_oe_n,
  // Group five pins.
  input  wire logic [7:0] group_five_pins_in,
  output var  logic [7:0] group_five_pins_out,
  output var  logic [7:0] group_five_pins_oe_n,
  // Group six pins.
  input  wire logic [7:0] group_six_pins_in,
  output var  logic [7:0] group_six_pins_out,
  output var  logic [7:0] group_six_pins_oe_n,
  // Watchdog and power LED requests from their own logic.
  input  wire logic       watchdog_timeout_req,
  input  wire logic       power_led_req,
  output var  logic       watchdog_timeout_out_n,
  output var  logic       power_led_out,
  // Decoded base address for the I/O decoder.
  output var  logic [15:0] io_base_addr,
  output var  logic        io_base_valid,
  // Interrupt.
  output var  logic        irq
);

  localparam int G = gpio_bank_pkg::GROUPS;

  // Registers shared by all units.
  logic [7:0] unit_sel_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_status_d;
  logic [7:0] irq_mask_q;

  // Registers of the unit holding groups five and six.
  logic [7:0] activation_q;
  logic [7:0] base_high_q;
  logic [7:0] base_low_q;
  logic [7:0] timeout_ctrl_q;

  // Per-group storage and views, index 0..2 for groups four..six.
  logic [7:0] dir_q      [G];
  logic [7:0] data_q     [G];
  logic [7:0] inv_q      [G];
  logic [7:0] pins_raw   [G];
  logic [7:0] pins_sync  [G];
  logic [7:0] events     [G];
  logic [7:0] group_rd   [G];
  logic [7:0] pin_out_q  [G];
  logic [7:0] pin_oe_n_q [G];
  logic [G-1:0] group_on;
  logic [G-1:0] group_edge;

  // Read path.
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic       wdt_q;
  logic       led_q;

  // Register map in short. Three offsets answer whatever unit is
  // selected: the unit select itself, the summary interrupt status and
  // its mask. Everything else belongs to one unit only. Unit 07h holds
  // group four, unit 08h holds groups five and six together with the
  // activation, base address and timeout control registers. An access
  // to an offset that the selected unit does not hold reads zero and a
  // write to it is dropped, so software that probes blindly cannot
  // disturb a neighbouring unit.
  // All decodes are plain compares against package constants, so a
  // change of placement stays in the package and never touches the
  // logic below. The decodes are combinational and are used in the
  // same cycle as the strobe that qualifies them.

  // Decodes of the registers that do not belong to one group.
  wire unit56      = (unit_sel_q == gpio_bank_pkg::UNIT_GROUP56);
  wire hit_unit    = (reg_addr == gpio_bank_pkg::UNIT_SELECT_OFS);
  wire hit_istat   = (reg_addr == gpio_bank_pkg::IRQ_STATUS_OFS);
  wire hit_imask   = (reg_addr == gpio_bank_pkg::IRQ_MASK_OFS);
  wire hit_act     = unit56 &&
                     (reg_addr == gpio_bank_pkg::ACTIVATION_OFS);
  wire hit_bhigh   = unit56 &&
                     (reg_addr == gpio_bank_pkg::BASE_HIGH_OFS);
  wire hit_blow    = unit56 &&
                     (reg_addr == gpio_bank_pkg::BASE_LOW_OFS);
  wire hit_timeout = unit56 &&
                     (reg_addr == gpio_bank_pkg::TIMEOUT_CTRL_OFS);

  // Activation bits decide whether groups five and six drive and record events; group four always does.
  assign group_on[0] = 1'b1;
  assign group_on[1] = activation_q[gpio_bank_pkg::ACT_G5_BIT];
  assign group_on[2] = activation_q[gpio_bank_pkg::ACT_G6_BIT];

  // Raw pin levels gathered into the group array.
  assign pins_raw[0] = group_four_pins_in;
  assign pins_raw[1] = group_five_pins_in;
  assign pins_raw[2] = group_six_pins_in;

  // Pin drivers and enables come straight from per-group flip-flops.
  assign group_four_pins_out  = pin_out_q[0];
  assign group_four_pins_oe_n = pin_oe_n_q[0];
  assign group_five_pins_out  = pin_out_q[1];
  assign group_five_pins_oe_n = pin_oe_n_q[1];
  assign group_six_pins_out   = pin_out_q[2];
  assign group_six_pins_oe_n  = pin_oe_n_q[2];

  // Each group owns a direction, a data, an inversion and an event
  // register. The data register is split per bit by direction: output
  // bits hold what software wrote, input bits show the synchronised pin
  // through the inversion mask and keep their stored value on a write.
  // Keeping the stored value means that turning an input back into an
  // output drives the last value that software wrote while it was an
  // output, not whatever the pin happened to show.
  // Pin drive and enable are registered, so they move two cycles after
  // the write strobe: one cycle for the register, one for the pin stage.
  // The extra stage keeps the pins free of decode glitches.
  // One copy of the group logic per pin group.
  for (genvar g = 0; g < G; g++) begin : grp
    wire in_unit  = (unit_sel_q == gpio_bank_pkg::GROUP_UNIT[g]);
    wire hit_dir  = in_unit && (reg_addr == gpio_bank_pkg::GROUP_DIR_OFS[g]);
    wire hit_data = in_unit &&
                    (reg_addr == gpio_bank_pkg::GROUP_DATA_OFS[g]);
    wire hit_inv  = in_unit && (reg_addr == gpio_bank_pkg::GROUP_INV_OFS[g]);
    wire hit_evt  = in_unit && (reg_addr == gpio_bank_pkg::GROUP_EVT_OFS[g]);
    wire evt_clr  = reg_rd && hit_evt;
    // Input bits keep their old value on a write; output bits take it.
    wire [7:0] data_d = (reg_wdata & ~dir_q[g]) | (data_q[g] & dir_q[g]);
    // Input pins read their level through the inversion mask.
    wire [7:0] pin_view = pins_sync[g] ^ inv_q[g];
    wire [7:0] data_view = (data_q[g] & ~dir_q[g]) |
                           (pin_view & dir_q[g]);

    // Synchronise the pins before anything looks at them.
    pin_sync #(
      .WIDTH     (8)
    ) u_sync (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .level_in  (pins_raw[g]),
      .level_out (pins_sync[g])
    );

    // Sticky either-edge status, cleared by a read of its register.
    edge_capture u_edges (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .level     (pins_sync[g]),
      .arm       (group_on[g]),
      .clear     (evt_clr),
      .events_q  (events[g]),
      .edge_seen (group_edge[g])
    );

    // Read contribution of this group; zero when no register matches.
    assign group_rd[g] = ({8{hit_dir}}  & dir_q[g])  |
                         ({8{hit_data}} & data_view) |
                         ({8{hit_inv}}  & inv_q[g])  |
                         ({8{hit_evt}}  & events[g]);

    // Direction, data and inversion storage.
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        dir_q[g]  <= gpio_bank_pkg::DIR_RST;
        data_q[g] <= gpio_bank_pkg::DATA_RST[g];
        inv_q[g]  <= gpio_bank_pkg::INV_RST;
      end else if (reg_wr) begin
        if (hit_dir) begin
          dir_q[g] <= reg_wdata;
        end
        if (hit_data) begin
          data_q[g] <= data_d;
        end
        if (hit_inv) begin
          inv_q[g] <= reg_wdata;
        end
      end
    end

    // Pin drive: an inactive group floats all of its pins.
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pin_out_q[g]  <= 8'h00;
        pin_oe_n_q[g] <= 8'hFF;
      end else begin
        pin_out_q[g]  <= data_q[g] ^ inv_q[g];
        pin_oe_n_q[g] <= group_on[g] ? dir_q[g] : 8'hFF;
      end
    end
  end

  // Read side. Every decode contributes its register masked by its own
  // hit, and the contributions are ORed. This costs a few gates more
  // than a priority mux but needs no ordering, and an offset that hits
  // nothing yields zero without a separate default path.
  // The read mux ORs the decodes together; at most one of them is hit.
  always_comb begin
    rd_mux = ({8{hit_unit}}    & unit_sel_q)     |
             ({8{hit_istat}}   & irq_status_q)   |
             ({8{hit_imask}}   & irq_mask_q)     |
             ({8{hit_act}}     & activation_q)   |
             ({8{hit_bhigh}}   & base_high_q)    |
             ({8{hit_blow}}    & base_low_q)     |
             ({8{hit_timeout}} & timeout_ctrl_q);
    for (int i = 0; i < G; i++) begin
      rd_mux = rd_mux | group_rd[i];
    end
  end

  // Read data stand only in the cycle after the strobe, so a stale value
  // is never mistaken for a second answer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // Unit selection and interrupt mask are plain storage.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unit_sel_q <= gpio_bank_pkg::UNIT_SELECT_RST;
      irq_mask_q <= gpio_bank_pkg::IRQ_RST;
    end else if (reg_wr) begin
      if (hit_unit) begin
        unit_sel_q <= reg_wdata;
      end
      if (hit_imask) begin
        irq_mask_q <= reg_wdata;
      end
    end
  end

  // Activation and timeout control keep only their defined bits.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      activation_q   <= gpio_bank_pkg::ACTIVATION_RST;
      timeout_ctrl_q <= gpio_bank_pkg::TIMEOUT_CTRL_RST;
    end else if (reg_wr) begin
      if (hit_act) begin
        activation_q <= reg_wdata & gpio_bank_pkg::ACTIVATION_MASK;
      end
      if (hit_timeout) begin
        timeout_ctrl_q <= reg_wdata & gpio_bank_pkg::TIMEOUT_CTRL_MASK;
      end
    end
  end

  // The base pair is two independent byte registers. Software writes the
  // high and the low byte one at a time, so for a cycle the combined
  // address may be half old and half new; the outside decoder must not
  // be used while software is moving the window.
  // Base address pair; the two low bits are forced to zero for alignment.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_high_q <= gpio_bank_pkg::BASE_RST;
      base_low_q  <= gpio_bank_pkg::BASE_RST;
    end else if (reg_wr) begin
      if (hit_bhigh) begin
        base_high_q <= reg_wdata;
      end
      if (hit_blow) begin
        base_low_q <= reg_wdata & gpio_bank_pkg::BASE_ALIGN_MASK;
      end
    end
  end

  // The decoder outside must ignore an address outside the legal window.
  assign io_base_addr  = {base_high_q, base_low_q};
  assign io_base_valid = (io_base_addr >= gpio_bank_pkg::BASE_MIN) &&
                         (io_base_addr <= gpio_bank_pkg::BASE_MAX);

  // The summary status holds one bit per group and is set by any new
  // edge that the group's capture logic records. It is independent of
  // the per-group event registers: reading one of those does not clear
  // the summary, and reading the summary does not clear the events.
  // Software that wants a quiet line reads both. Because a new edge wins
  // over the clearing read, an event in the read cycle is never lost; it
  // simply shows up again on the next read.
  // Summary interrupt status: a new edge wins over the read that clears.
  assign irq_status_d = ((reg_rd && hit_istat) ? 8'h00 : irq_status_q) |
                        {5'h00, group_edge};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status_q <= gpio_bank_pkg::IRQ_RST;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // The watchdog counter and the LED blinker live elsewhere; this bank
  // only gates their requests with activation bit 0. Both outputs are
  // registered so that a request arriving from another block cannot
  // glitch a pin, at the price of one cycle of delay.
  // Watchdog timeout (active low) and power LED are gated by bit 0.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_q <= 1'b0;
      led_q <= 1'b0;
    end else begin
      wdt_q <= activation_q[gpio_bank_pkg::ACT_WDT_BIT] &&
               watchdog_timeout_req;
      led_q <= activation_q[gpio_bank_pkg::ACT_WDT_BIT] &&
               power_led_req;
    end
  end

  assign watchdog_timeout_out_n = ~wdt_q;
  assign power_led_out          = led_q;

endmodule // gpio_group_config_bank

`default_nettype wire

// ### hdl/gpio_bank_pkg.sv
package gpio_bank_pkg;

  // Widths of the register port and the number of pin groups.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int GROUPS = 3;

  // Offsets that do not depend on the selected unit.
  localparam logic [7:0] UNIT_SELECT_OFS = 8'h07;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h09;

  // Unit numbers: the fourth group lives in one unit, groups five and six
  // together with the activation and base registers in the next.
  localparam logic [7:0] UNIT_GROUP4   = 8'h07;
  localparam logic [7:0] UNIT_GROUP56  = 8'h08;
  localparam logic [7:0] UNIT_SELECT_RST = 8'h08;

  // Registers of the unit that holds groups five and six.
  localparam logic [7:0] ACTIVATION_OFS   = 8'h30;
  localparam logic [7:0] BASE_HIGH_OFS    = 8'h60;
  localparam logic [7:0] BASE_LOW_OFS     = 8'h61;
  localparam logic [7:0] TIMEOUT_CTRL_OFS = 8'hF5;

  // Activation register layout and reset value.
  localparam int         ACT_WDT_BIT     = 0;
  localparam int         ACT_G5_BIT      = 1;
  localparam int         ACT_G6_BIT      = 2;
  localparam logic [7:0] ACTIVATION_RST  = 8'h02;
  localparam logic [7:0] ACTIVATION_MASK = 8'h07;

  // Base address window and alignment.
  localparam logic [15:0] BASE_MIN        = 16'h0100;
  localparam logic [15:0] BASE_MAX        = 16'h0FF8;
  localparam logic [7:0]  BASE_ALIGN_MASK = 8'hFC;
  localparam logic [7:0]  BASE_RST        = 8'h00;

  // Timeout control: bits 4..1 are storage, the rest reserved.
  localparam logic [7:0] TIMEOUT_CTRL_MASK = 8'h1E;
  localparam logic [7:0] TIMEOUT_CTRL_RST  = 8'h00;

  // Per-group reset values; index 0, 1, 2 are groups four, five, six.
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] INV_RST = 8'h00;
  localparam logic [7:0] EVT_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [7:0] DATA_RST [GROUPS] = '{8'h00, 8'h00, 8'h1F};

  // Per-group register placement.
  localparam logic [7:0] GROUP_UNIT     [GROUPS] = '{8'h07, 8'h08, 8'h08};
  localparam logic [7:0] GROUP_DIR_OFS  [GROUPS] = '{8'hE4, 8'hE0, 8'hE4};
  localparam logic [7:0] GROUP_DATA_OFS [GROUPS] = '{8'hE5, 8'hE1, 8'hE5};
  localparam logic [7:0] GROUP_INV_OFS  [GROUPS] = '{8'hE6, 8'hE2, 8'hE6};
  localparam logic [7:0] GROUP_EVT_OFS  [GROUPS] = '{8'hE7, 8'hE3, 8'hE7};

endpackage

// ### hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Raw and synchronised levels.
  input  wire logic [WIDTH-1:0] level_in,
  output var  logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_q;

  // Two stages; only the second stage reads the first.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q    <= '0;
      level_out <= '0;
    end else begin
      meta_q    <= level_in;
      level_out <= meta_q;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ### hdl/edge_capture.sv
`timescale 1ns/1ps
`default_nettype none

module edge_capture (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Synchronised pin levels and control.
  input  wire logic [7:0] level,
  input  wire logic       arm,
  input  wire logic       clear,
  // Sticky events and a pulse for any new edge.
  output var  logic [7:0] events_q,
  output var  logic       edge_seen
);

  logic [7:0] prev_q;
  logic       primed_q;
  logic [7:0] edges;
  logic [7:0] events_d;

  // The first sampled level only primes the history, but the synchroniser
  // still reads zero then, so a pin high out of reset shows as a rising edge.
  assign edges     = (primed_q && arm) ? (level ^ prev_q) : 8'h00;
  assign events_d  = (clear ? 8'h00 : events_q) | edges;
  assign edge_seen = |edges;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_q   <= 8'h00;
      primed_q <= 1'b0;
      events_q <= gpio_bank_pkg::EVT_RST;
    end else begin
      prev_q   <= level;
      primed_q <= 1'b1;
      events_q <= events_d;
    end
  end

endmodule // edge_capture

`default_nettype wire

// ### sim/gpio_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_bank_checker (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port.
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Pins.
  input wire logic [7:0]  group_five_pins_out,
  input wire logic [7:0]  group_six_pins_out,
  input wire logic [7:0]  group_five_pins_oe_n,
  input wire logic [7:0]  group_six_pins_oe_n,
  // Side functions and base decode.
  input wire logic        watchdog_timeout_req,
  input wire logic        power_led_req,
  input wire logic        watchdog_timeout_out_n,
  input wire logic        power_led_out,
  input wire logic [15:0] io_base_addr,
  input wire logic        io_base_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // A lone read strobe followed by an idle cycle.
  sequence s_lone_read;
    reg_rd ##1 !reg_rd;
  endsequence

  // Read data stands for one cycle only, so a stale value is never seen.
  chk_rdata_one_cycle: assert property (s_lone_read |=> reg_rdata == 8'h00)
    else $error("read data held too long");
  chk_oe_reset_inputs: assert property ($fell(sys_rst) |->
    group_five_pins_oe_n == 8'hFF && group_six_pins_oe_n == 8'hFF)
    else $error("pins not inputs after reset");
  chk_six_reset_drive: assert property ($fell(sys_rst) |->
    ##[0:2] group_six_pins_out == 8'h1F)
    else $error("group six drive not 1F after reset");
  // Pin direction and drive move only two cycles after a register write.
  chk_oe_after_write: assert property (!$stable(group_five_pins_oe_n) |->
    $past(reg_wr, 2))
    else $error("enable changed without a write");
  chk_out_after_write: assert property (!$stable(group_five_pins_out) |->
    $past(reg_wr, 2))
    else $error("drive changed without a write");
  chk_led_gated_req: assert property (power_led_out |->
    $past(power_led_req))
    else $error("power led without request");
  chk_wdt_gated_req: assert property (!watchdog_timeout_out_n |->
    $past(watchdog_timeout_req))
    else $error("watchdog output without request");
  chk_side_pair_same: assert property (
    $past(power_led_req) == $past(watchdog_timeout_req) |->
    power_led_out != watchdog_timeout_out_n)
    else $error("led and watchdog gating differ");
  chk_base_valid_range: assert property (io_base_valid ==
    (io_base_addr >= 16'h0100 && io_base_addr <= 16'h0FF8))
    else $error("base valid wrong");
  chk_base_word_align: assert property (io_base_addr[1:0] == 2'h0)
    else $error("base not aligned");
endmodule // gpio_bank_checker

`default_nettype wire

// ### sim/gpio_group_config_bank_test.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_group_config_bank_test;
  // Stimulus and observed outputs.
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [7:0]  g4_in = 8'h00;
  logic [7:0]  g5_in = 8'h00;
  logic [7:0]  g6_in = 8'h00;
  logic [7:0]  g4_out;
  logic [7:0]  g4_oe_n;
  logic [7:0]  g5_out;
  logic [7:0]  g6_out;
  logic [7:0]  g5_oe_n;
  logic [7:0]  g6_oe_n;
  logic        wdt_req = 1'b0;
  logic        led_req = 1'b0;
  logic        wdt_n;
  logic        led;
  logic [15:0] base;
  logic        base_ok;
  logic        irq;
  int          err_total = 0;
  int          total_checks = 0;

  // Clock at 125 MHz.
  always #4 clk = ~clk;

  gpio_group_config_bank dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .group_four_pins_in(g4_in),
    .group_four_pins_out(g4_out), .group_four_pins_oe_n(g4_oe_n),
    .group_five_pins_in(g5_in), .group_five_pins_out(g5_out),
    .group_five_pins_oe_n(g5_oe_n), .group_six_pins_in(g6_in),
    .group_six_pins_out(g6_out), .group_six_pins_oe_n(g6_oe_n),
    .watchdog_timeout_req(wdt_req), .power_led_req(led_req),
    .watchdog_timeout_out_n(wdt_n), .power_led_out(led),
    .io_base_addr(base), .io_base_valid(base_ok), .irq(irq));

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits n edges, then steps past them so outputs have settled.
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe.
  task automatic rd(input string what, input logic [7:0] a,
                    input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  task automatic t_reset();
    rd("activation", 8'h30, 8'h02);
    rd("base high", 8'h60, 8'h00);
    rd("base low", 8'h61, 8'h00);
    rd("g5 dir", 8'hE0, 8'hFF);
    rd("g6 dir", 8'hE4, 8'hFF);
    rd("g5 inv", 8'hE2, 8'h00);
    rd("g5 events", 8'hE3, 8'h00);
    rd("unmapped", 8'h40, 8'h00);
    check("g6 drive", 16'h001F, {8'h00, g6_out});
    check("g4 oe", 16'h00FF, {8'h00, g4_oe_n});
    check("g4 drive", 16'h0000, {8'h00, g4_out});
  endtask

  task automatic t_side();
    @(posedge clk);
    wdt_req <= 1'b1;
    led_req <= 1'b1;
    pause(3);
    check("led off", 16'h0000, {15'h0000, led});
    check("wdt off", 16'h0001, {15'h0000, wdt_n});
    wr(8'h30, 8'h03);
    pause(2);
    check("led on", 16'h0001, {15'h0000, led});
    check("wdt on", 16'h0000, {15'h0000, wdt_n});
  endtask

  // Upper nibble output, lower nibble input; pin edges also arm events.
  task automatic t_data();
    @(posedge clk);
    g5_in <= 8'h3C;
    wr(8'hE0, 8'h0F);
    wr(8'hE1, 8'hA5);
    pause(3);
    check("g5 oe", 16'h000F, {8'h00, g5_oe_n});
    check("g5 drive", 16'h000A, {12'h000, g5_out[7:4]});
    rd("g5 data", 8'hE1, 8'hAC);
    wr(8'hE2, 8'hFF);
    rd("g5 inv data", 8'hE1, 8'hA3);
    pause(2);
    check("g5 inv drive", 16'h0005, {12'h000, g5_out[7:4]});
  endtask

  task automatic t_events();
    rd("g5 edges", 8'hE3, 8'h3C);
    rd("g5 cleared", 8'hE3, 8'h00);
    wr(8'hE3, 8'hFF);
    rd("g5 no write", 8'hE3, 8'h00);
    wr(8'h09, 8'h07);
    pause(2);
    check("irq up", 16'h0001, {15'h0000, irq});
    rd("irq status", 8'h08, 8'h02);
    pause(1);
    check("irq down", 16'h0000, {15'h0000, irq});
    @(posedge clk);
    g6_in <= 8'h01;
    pause(6);
    rd("g6 inactive", 8'hE7, 8'h00);
    wr(8'h30, 8'h07);
    g6_in <= 8'h03;
    pause(6);
    rd("g6 edges", 8'hE7, 8'h02);
    wr(8'h07, 8'h07);
    g4_in <= 8'h80;
    pause(6);
    rd("g4 edges", 8'hE7, 8'h80);
    wr(8'hE4, 8'hFE);
    wr(8'hE5, 8'h01);
    pause(3);
    check("g4 oe out", 16'h00FE, {8'h00, g4_oe_n});
    check("g4 drive out", 16'h0001, {8'h00, g4_out});
    wr(8'h07, 8'h08);
  endtask

  task automatic t_base();
    wr(8'h60, 8'h01);
    wr(8'h61, 8'h23);
    pause(1);
    check("base", 16'h0120, base);
    check("base ok", 16'h0001, {15'h0000, base_ok});
    wr(8'h60, 8'h0F);
    wr(8'h61, 8'hFF);
    pause(1);
    check("base top", 16'h0FFC, base);
    check("base high out", 16'h0000, {15'h0000, base_ok});
    wr(8'h60, 8'h00);
    pause(1);
    check("base low out", 16'h0000, {15'h0000, base_ok});
    wr(8'hF5, 8'hFF);
    rd("timeout ctl", 8'hF5, 8'h1E);
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The sequence needs about 125 cycles; this limit is far beyond.
  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    pause(3);
    t_reset();
    t_side();
    t_data();
    t_events();
    t_base();
    stop_test();
  end
endmodule // gpio_group_config_bank_test

bind gpio_group_config_bank gpio_bank_checker chk (
  .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .group_five_pins_out(group_five_pins_out),
  .group_six_pins_out(group_six_pins_out),
  .group_five_pins_oe_n(group_five_pins_oe_n),
  .group_six_pins_oe_n(group_six_pins_oe_n),
  .watchdog_timeout_req(watchdog_timeout_req),
  .power_led_req(power_led_req),
  .watchdog_timeout_out_n(watchdog_timeout_out_n),
  .power_led_out(power_led_out), .io_base_addr(io_base_addr),
  .io_base_valid(io_base_valid));

`default_nettype wire
